// File: logic/reset_cause_status.sv
/*
 Reset-cause status block: power status flags, power-up delay sequencer,
 reset event interrupts and an APB slave for the registers.
 Assumes rst is the device power-on reset, configuration and reset-source
 pins are asynchronous levels, and the APB master keeps to the protocol.
*/
// The APB register port and the placing of the registers are this design's own decisions.
module reset_cause_status #(
    parameter int PWRUP_DELAY_CYCLES = reset_cause_pkg::PWRUP_DELAY_CYCLES,
    parameter int TIMER_W = reset_cause_pkg::TIMER_W
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst,
    // Configuration word bits
    input wire logic brownout_enable_cfg,
    input wire logic powerup_timer_enable_cfg,
    // Reset sources
    input wire logic brownout_detect,
    input wire logic ext_reset,
    // APB slave
    input wire reset_cause_pkg::apb_req_t apb_req,
    output reset_cause_pkg::apb_rsp_t apb_rsp_r,
    // Status and control outputs
    output logic brownout_flag_r,
    output logic por_flag_r,
    output logic reset_hold_r,
    output logic pwrt_active_r,
    output logic irq_r
);

    // Parameter sanity
    generate
        if (PWRUP_DELAY_CYCLES < 1 || PWRUP_DELAY_CYCLES > (2 ** TIMER_W)) begin : g_bad_delay
            $error("power-up delay does not fit the timer width");
        end
    endgenerate

    // Synchronised pins
    reset_cause_pkg::pin_vec_t pins_raw;
    reset_cause_pkg::pin_vec_t pins_s;
    logic bod_prev_r;
    logic ext_prev_r;
    logic bod_on;
    logic timer_on;
    logic bod_rise;
    logic ext_rise;

    assign pins_raw.ext_reset = ext_reset;
    assign pins_raw.brownout_detect = brownout_detect;
    assign pins_raw.powerup_timer_enable_cfg = powerup_timer_enable_cfg;
    assign pins_raw.brownout_enable_cfg = brownout_enable_cfg;

    pin_sync #(
        .W($bits(reset_cause_pkg::pin_vec_t))
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // Event edges; a detector is ignored while brown-out is off
    assign bod_on = pins_s.brownout_enable_cfg;
    assign timer_on = bod_on | pins_s.powerup_timer_enable_cfg;
    assign bod_rise = bod_on & pins_s.brownout_detect & ~bod_prev_r;
    assign ext_rise = pins_s.ext_reset & ~ext_prev_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bod_prev_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            bod_prev_r <= pins_s.brownout_detect;
            ext_prev_r <= pins_s.ext_reset;
        end
    end

    // APB decode
    logic apb_access;
    logic apb_done;
    logic wr_done;
    logic hit_ps;
    logic hit_irq;
    logic hit_mask;
    logic hit_info;
    logic addr_hit;
    logic [reset_cause_pkg::DATA_W-1:0] rd_mux;

    assign apb_access = apb_req.psel & apb_req.penable;
    assign apb_done = apb_access & apb_rsp_r.pready;
    assign wr_done = apb_done & apb_req.pwrite & ~apb_rsp_r.pslverr;
    assign hit_ps = apb_req.paddr == reset_cause_pkg::OFS_POWER_STATUS;
    assign hit_irq = apb_req.paddr == reset_cause_pkg::OFS_IRQ_STATUS;
    assign hit_mask = apb_req.paddr == reset_cause_pkg::OFS_IRQ_MASK;
    assign hit_info = apb_req.paddr == reset_cause_pkg::OFS_CAUSE_INFO;
    assign addr_hit = hit_ps | hit_irq | hit_mask | hit_info;

    // Sequencer state
    reset_cause_pkg::seq_state_t state_r;
    reset_cause_pkg::seq_state_t state_nxt;
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;
    logic settle_done;
    logic [TIMER_W-1:0] tmr_r;
    logic [TIMER_W-1:0] tmr_nxt;
    logic tmr_load;
    logic hold_nxt;
    logic poweron_ev;

    // Registers
    logic brownout_nxt;
    logic por_nxt;
    logic [reset_cause_pkg::IRQ_W-1:0] irq_st_r;
    logic [reset_cause_pkg::IRQ_W-1:0] irq_st_nxt;
    logic [reset_cause_pkg::IRQ_W-1:0] irq_ev;
    logic [reset_cause_pkg::IRQ_W-1:0] irq_w1c;
    logic [reset_cause_pkg::IRQ_W-1:0] mask_r;
    logic [reset_cause_pkg::IRQ_W-1:0] mask_nxt;

    // Read data; only two flags exist in the power status word
    assign rd_mux = hit_ps ? {30'h0, por_flag_r, brownout_flag_r} :
                    hit_irq ? {29'h0, irq_st_r} :
                    hit_mask ? {29'h0, mask_r} :
                    hit_info ? {26'h0, state_r, reset_hold_r, pwrt_active_r,
                                pins_s.powerup_timer_enable_cfg, bod_on} :
                    32'h0;

    // One wait state, so read data always leave a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            apb_rsp_r <= '0;
        end else begin
            apb_rsp_r.pready <= apb_access & ~apb_rsp_r.pready;
            apb_rsp_r.pslverr <= apb_access & ~apb_rsp_r.pready & ~addr_hit;
            apb_rsp_r.prdata <= (apb_access & ~apb_rsp_r.pready & ~apb_req.pwrite) ?
                                rd_mux : 32'h0;
        end
    end

    // Power status flags; hardware clear beats a software set
    assign brownout_nxt = bod_rise ? 1'b0 :
                          (wr_done & hit_ps) ? apb_req.pwdata[reset_cause_pkg::BIT_BROWNOUT] :
                          brownout_flag_r;
    assign por_nxt = (wr_done & hit_ps) ? apb_req.pwdata[reset_cause_pkg::BIT_POR] :
                     por_flag_r;

    // Power-on values are constants taken at the reset itself
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            brownout_flag_r <= reset_cause_pkg::BROWNOUT_FLAG_RST;
            por_flag_r <= reset_cause_pkg::POR_FLAG_RST;
        end else begin
            brownout_flag_r <= brownout_nxt;
            por_flag_r <= por_nxt;
        end
    end

    // Sticky events, write one to clear, a new event wins
    assign irq_ev = {ext_rise, poweron_ev, bod_rise};
    assign irq_w1c = (wr_done & hit_irq) ? apb_req.pwdata[reset_cause_pkg::IRQ_W-1:0] : 3'h0;
    assign irq_st_nxt = (irq_st_r & ~irq_w1c) | irq_ev;
    assign mask_nxt = (wr_done & hit_mask) ? apb_req.pwdata[reset_cause_pkg::IRQ_W-1:0] : mask_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_st_r <= reset_cause_pkg::IRQ_STATUS_RST;
            mask_r <= reset_cause_pkg::IRQ_MASK_RST;
            irq_r <= 1'b0;
        end else begin
            irq_st_r <= irq_st_nxt;
            mask_r <= mask_nxt;
            irq_r <= |(irq_st_nxt & mask_nxt);
        end
    end

    // Settle counter lets the synchronised straps become valid
    assign settle_done = settle_r == reset_cause_pkg::SETTLE_CYCLES;
    assign settle_nxt = (state_r == reset_cause_pkg::ST_START && !settle_done) ?
                        settle_r + 2'h1 : settle_r;
    assign poweron_ev = (state_r == reset_cause_pkg::ST_START) & settle_done;

    // Next sequencer state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            reset_cause_pkg::ST_START: begin
                if (settle_done) begin
                    state_nxt = timer_on ? reset_cause_pkg::ST_HOLD : reset_cause_pkg::ST_RUN;
                end
            end
            reset_cause_pkg::ST_HOLD: begin
                if (!bod_rise && tmr_r == '0) begin
                    state_nxt = reset_cause_pkg::ST_RUN;
                end
            end
            reset_cause_pkg::ST_RUN: begin
                if (bod_rise && timer_on) begin
                    state_nxt = reset_cause_pkg::ST_HOLD;
                end
            end
            default: begin
                state_nxt = reset_cause_pkg::ST_START;
            end
        endcase
    end

    // A brown-out during the hold restarts the full delay
    assign tmr_load = (state_nxt == reset_cause_pkg::ST_HOLD) &
                      ((state_r != reset_cause_pkg::ST_HOLD) | bod_rise);
    assign tmr_nxt = tmr_load ? TIMER_W'(PWRUP_DELAY_CYCLES - 1) :
                     (state_r == reset_cause_pkg::ST_HOLD && tmr_r != '0) ?
                     tmr_r - 1'b1 : tmr_r;
    // A brown-out is seen only with the timer on, so it always gives the full delay
    assign hold_nxt = (state_nxt != reset_cause_pkg::ST_RUN) | bod_rise;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= reset_cause_pkg::ST_START;
            settle_r <= 2'h0;
            tmr_r <= '0;
            reset_hold_r <= 1'b1;
            pwrt_active_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            settle_r <= settle_nxt;
            tmr_r <= tmr_nxt;
            reset_hold_r <= hold_nxt;
            pwrt_active_r <= timer_on;
        end
    end

    // Checks
    logic first_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence hold_entry_s;
        state_r != reset_cause_pkg::ST_HOLD ##1 state_r == reset_cause_pkg::ST_HOLD;
    endsequence

    sequence start_exit_s;
        state_r == reset_cause_pkg::ST_START && settle_done;
    endsequence

    // Delay has run out and no new brown-out restarts it
    sequence hold_done_s;
        state_r == reset_cause_pkg::ST_HOLD && tmr_r == '0 && !bod_rise;
    endsequence

    por_values_a: assert property (first_r |-> brownout_flag_r && !por_flag_r)
        else $error("flags wrong after power-on reset");
    por_steady_a: assert property (!(wr_done && hit_ps) |=> $stable(por_flag_r))
        else $error("power-on flag moved without a write");
    bod_clears_a: assert property (bod_rise |=> !brownout_flag_r && irq_st_r[0])
        else $error("brown-out did not clear its flag");
    bod_off_a: assert property (!bod_on |-> !bod_rise)
        else $error("brown-out event while detection disabled");
    status_width_a: assert property (apb_rsp_r.pready && hit_ps |->
                                     apb_rsp_r.prdata[31:2] == 30'h0)
        else $error("power status reads beyond two flags");
    timer_forced_a: assert property (start_exit_s and timer_on |=> state_r ==
                                     reset_cause_pkg::ST_HOLD ##1 reset_hold_r)
        else $error("power-up timer not started");
    no_timer_a: assert property (start_exit_s and !timer_on |=>
                                 state_r == reset_cause_pkg::ST_RUN)
        else $error("hold entered with timer disabled");
    hold_load_a: assert property (hold_entry_s |-> tmr_r == TIMER_W'(PWRUP_DELAY_CYCLES - 1))
        else $error("hold entered without full delay");
    apb_wait_a: assert property (apb_access && !apb_rsp_r.pready |=> apb_rsp_r.pready)
        else $error("APB answer late");

    // Other reset sources leave both flags where software put them
    ext_keeps_a: assert property (ext_rise && !bod_rise && !(wr_done && hit_ps) |=>
                                  $stable(por_flag_r) && $stable(brownout_flag_r))
        else $error("flags moved on another reset source");
    // A plain write stores both flags; a same-cycle brown-out is excluded
    sw_write_a: assert property (wr_done && hit_ps && !bod_rise |=>
                                 {por_flag_r, brownout_flag_r} == $past(apb_req.pwdata[1:0]))
        else $error("power status write not stored");
    hold_exit_a: assert property (hold_done_s |=>
                                  state_r == reset_cause_pkg::ST_RUN && !reset_hold_r)
        else $error("hold did not end with the delay");
    // Refused accesses answer with an error and no data
    apb_err_a: assert property (apb_access && !apb_rsp_r.pready && !addr_hit |=>
                                apb_rsp_r.pslverr && apb_rsp_r.prdata == 32'h0)
        else $error("unmapped access not refused");

endmodule

// File: logic/reset_cause_pkg.sv
/*
 Shared constants, register map and carrier types for the reset-cause
 status block. Assumes a single 125 MHz system clock and an APB master
 with 32-bit data; the block reset is the power-on reset of the device.
*/
// Behaviour
// - Power status register holds two flags: bit 0 brown-out, bit 1 power-on.
// - With brown-out detection enabled, power-on reset leaves the brown-out flag at one.
// - With brown-out detection disabled, the brown-out flag means nothing.
// - Software sets the brown-out flag; a brown-out reset clears it.
// - Power-on reset clears the power-on flag; other resets leave it alone.
package reset_cause_pkg;

    // Bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_POWER_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CAUSE_INFO = 8'h0C;

    // Power status register fields
    localparam int BIT_BROWNOUT = 0;
    localparam int BIT_POR = 1;
    localparam int POWER_STATUS_W = 2;

    // Interrupt status and mask fields
    localparam int IRQ_BROWNOUT = 0;
    localparam int IRQ_POWERON = 1;
    localparam int IRQ_EXT_RESET = 2;
    localparam int IRQ_W = 3;

    // Values after reset
    localparam logic BROWNOUT_FLAG_RST = 1'b1;
    localparam logic POR_FLAG_RST = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_STATUS_RST = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // Timing
    localparam int CLK_HZ = 125_000_000;
    localparam int PWRUP_DELAY_MS = 72;
    localparam int PWRUP_DELAY_CYCLES = PWRUP_DELAY_MS * (CLK_HZ / 1000);
    localparam int TIMER_W = 24;
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;

    // Request from the APB master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    // Answer to the APB master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;

    // Pins sampled through the synchroniser
    typedef struct packed {
        logic ext_reset;
        logic brownout_detect;
        logic powerup_timer_enable_cfg;
        logic brownout_enable_cfg;
    } pin_vec_t;

    // Power-up sequencer, Gray along start, hold, run
    typedef enum logic [1:0] {
        ST_START = 2'h0,
        ST_HOLD = 2'h1,
        ST_RUN = 2'h3
    } seq_state_t;

endpackage

// File: logic/pin_sync.sv
/*
 Two-flop synchroniser for a vector of slow, independent levels.
 Assumes each bit is a quasi-static level; no bus coherence is offered.
*/
module pin_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    generate
        if (W < 1) begin : g_bad_width
            $error("pin_sync width must be at least one");
        end
    endgenerate

    // First stage is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// File: dv/reset_cause_status_tb_top.sv
/*
 Self-checking bench for the reset-cause status block: power status flags,
 reset-source pins, interrupt line and APB register traffic.
 Assumes the APB slave answers with pready and a power-up delay of 16 cycles.
*/
module reset_cause_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Short delay keeps the hold phases brief
    localparam int DELAY = 16;

    logic clk;
    logic rst;
    logic brownout_enable_cfg;
    logic powerup_timer_enable_cfg;
    logic brownout_detect;
    logic ext_reset;
    reset_cause_pkg::apb_req_t apb_req;
    reset_cause_pkg::apb_rsp_t apb_rsp_r;
    logic brownout_flag_r;
    logic por_flag_r;
    logic reset_hold_r;
    logic pwrt_active_r;
    logic irq_r;
    int miscompares;
    int num_checks;
    logic [31:0] rd;
    logic err;

    reset_cause_status #(
        .PWRUP_DELAY_CYCLES(DELAY)
    ) dut (
        .clk(clk),
        .rst(rst),
        .brownout_enable_cfg(brownout_enable_cfg),
        .powerup_timer_enable_cfg(powerup_timer_enable_cfg),
        .brownout_detect(brownout_detect),
        .ext_reset(ext_reset),
        .apb_req(apb_req),
        .apb_rsp_r(apb_rsp_r),
        .brownout_flag_r(brownout_flag_r),
        .por_flag_r(por_flag_r),
        .reset_hold_r(reset_hold_r),
        .pwrt_active_r(pwrt_active_r),
        .irq_r(irq_r)
    );

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        apb_req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apb_req.penable <= 1'h1;
        // No limit here: the watchdog ends a hung transfer
        do begin
            @(posedge clk);
            n++;
        end while (apb_rsp_r.pready !== 1'h1);
        rd = apb_rsp_r.prdata;
        err = apb_rsp_r.pslverr;
        chk("apb_wait", n, 32'h2);
        apb_req.psel <= 1'h0;
        apb_req.penable <= 1'h0;
    endtask

    // Read one register and compare the word
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    // Bounded wait for the end of the reset hold
    task automatic wait_release();
        int n;
        n = 0;
        while (reset_hold_r !== 1'h0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("hold_release", {31'h0, reset_hold_r}, 32'h0);
    endtask

    // Power-on values, brown-out enabled
    task automatic t_power_on();
        chk("bo_flag_por", {31'h0, brownout_flag_r}, 32'h1);
        chk("por_flag_por", {31'h0, por_flag_r}, 32'h0);
        wait_release();
        rd_chk("status_por", 8'h00, 32'h1);
        // Timer forced on although its own enable is low
        rd_chk("cause_info", 8'h0C, 32'h35);
        chk("pwrt_active", {31'h0, pwrt_active_r}, 32'h1);
    endtask

    // Power-on event, masking and write-one-to-clear
    task automatic t_irq();
        rd_chk("irq_st_po", 8'h04, 32'h2);
        chk("irq_masked", {31'h0, irq_r}, 32'h0);
        apb(1'h1, 8'h08, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq_on", {31'h0, irq_r}, 32'h1);
        apb(1'h1, 8'h04, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq_off", {31'h0, irq_r}, 32'h0);
        rd_chk("irq_st_clr", 8'h04, 32'h0);
    endtask

    // Software marks the power-on reset as seen
    task automatic t_sw_set();
        apb(1'h1, 8'h00, 32'h3);
        rd_chk("status_set", 8'h00, 32'h3);
        chk("por_flag_set", {31'h0, por_flag_r}, 32'h1);
    endtask

    // Other reset source leaves both flags alone
    task automatic t_ext();
        ext_reset <= 1'h1;
        repeat (6) @(posedge clk);
        ext_reset <= 1'h0;
        chk("por_flag_ext", {31'h0, por_flag_r}, 32'h1);
        chk("bo_flag_ext", {31'h0, brownout_flag_r}, 32'h1);
        rd_chk("irq_st_ext", 8'h04, 32'h4);
        apb(1'h1, 8'h04, 32'h4);
        rd_chk("status_ext", 8'h00, 32'h3);
    endtask

    // Brown-out clears its flag and restarts the delay
    task automatic t_brownout();
        brownout_detect <= 1'h1;
        repeat (6) @(posedge clk);
        brownout_detect <= 1'h0;
        chk("bo_flag_evt", {31'h0, brownout_flag_r}, 32'h0);
        chk("por_flag_bo", {31'h0, por_flag_r}, 32'h1);
        repeat (10) @(posedge clk);
        chk("hold_bor", {31'h0, reset_hold_r}, 32'h1);
        wait_release();
        rd_chk("status_bo", 8'h00, 32'h2);
        apb(1'h1, 8'h00, 32'h3);
        rd_chk("status_rearm", 8'h00, 32'h3);
    endtask

    // Timer follows its own enable once brown-out is off
    task automatic t_timer_cfg();
        brownout_enable_cfg <= 1'h0;
        repeat (5) @(posedge clk);
        chk("pwrt_off", {31'h0, pwrt_active_r}, 32'h0);
        powerup_timer_enable_cfg <= 1'h1;
        repeat (5) @(posedge clk);
        chk("pwrt_own", {31'h0, pwrt_active_r}, 32'h1);
        // Detector pulse is ignored while detection is off
        brownout_detect <= 1'h1;
        repeat (6) @(posedge clk);
        brownout_detect <= 1'h0;
        chk("bo_flag_off", {31'h0, brownout_flag_r}, 32'h1);
        chk("hold_bo_off", {31'h0, reset_hold_r}, 32'h0);
    endtask

    // Unmapped read errors, read-only write is dropped
    task automatic t_bad();
        apb(1'h0, 8'h10, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        apb(1'h1, 8'h0C, 32'hFFFFFFFF);
        chk("ro_err", {31'h0, err}, 32'h0);
        rd_chk("ro_keep", 8'h0C, 32'h36);
    endtask

    // Second power-on reset clears the flag that software had set
    task automatic t_repower();
        brownout_enable_cfg <= 1'h1;
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk("por_flag_repower", {31'h0, por_flag_r}, 32'h0);
        chk("bo_flag_repower", {31'h0, brownout_flag_r}, 32'h1);
        wait_release();
        rd_chk("status_repower", 8'h00, 32'h1);
        rd_chk("irq_st_repower", 8'h04, 32'h2);
    endtask

    // Verdict and end of run
    task automatic results();
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #(3000 * 8);
        miscompares++;
        results();
    end

    // Main sequence
    initial begin
        miscompares = 0;
        num_checks = 0;
        rst = 1'h1;
        brownout_enable_cfg = 1'h1;
        powerup_timer_enable_cfg = 1'h0;
        brownout_detect = 1'h0;
        ext_reset = 1'h0;
        apb_req = '0;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_power_on();
        t_irq();
        t_sw_set();
        t_ext();
        t_brownout();
        t_timer_cfg();
        t_bad();
        t_repower();
        results();
    end
endmodule
